// [aux_regulator_config_control.sv]
// configuration, lock and on/off control of the auxiliary regulator
//
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`include "aux_reg_defs.svh"

module aux_regulator_config_control (
	input  wire logic                   mclk,
	input  wire logic                   resetn,
	input  wire logic                   soft_reset,
	input  wire aux_reg_pkg::sys_mode_t sys_mode,
	input  wire aux_reg_pkg::sense_t    sense_pins,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic      [31:0]            hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic                        aux_on,
	output logic                        aux_level_1v8,
	output logic                        high_power_on,
	output logic                        low_power_on,
	output logic                        serial_fail
);

	aux_reg_pkg::aux_state_t s_r;
	aux_reg_pkg::aux_state_t s_nxt;
	aux_reg_pkg::sense_t     sense;
	aux_reg_pkg::reg_wr_t    wr;
	logic [`AUX_ADDR_W-1:0]  rd_addr;
	logic [`AUX_DATA_W-1:0]  rd_data;
	logic                    wr_ctrl;
	logic                    wr_stat;
	logic                    want_en;
	logic                    want_ls;
	logic                    wanted;

	// analog comparators are asynchronous to mclk
	pin_sync #(
		.W(`SENSE_W)
	) u_sense_sync (
		.mclk     (mclk),
		.resetn   (resetn),
		.pin_in   (sense_pins),
		.sync_out (sense)
	);

	ahb_reg_slave u_bus (
		.mclk      (mclk),
		.resetn    (resetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.rd_data   (rd_data),
		.rd_addr   (rd_addr),
		.wr        (wr),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp)
	);

	// whether the configured regulator should run in the given system mode
	function automatic logic mode_wants_on(
		input aux_reg_pkg::cfg_t      cfg,
		input aux_reg_pkg::sys_mode_t mode,
		input logic                   sa_on,
		input logic                   stop_keep
	);
		logic on;
		on = 1'b0;
		unique case (cfg)
			aux_reg_pkg::CFG_STANDALONE: begin
				// init and fail-safe force off, other modes hold the stored choice
				on = sa_on && mode != aux_reg_pkg::MODE_INIT
					&& mode != aux_reg_pkg::MODE_FAIL;
			end
			aux_reg_pkg::CFG_LOADSHARE: begin
				unique case (mode)
					aux_reg_pkg::MODE_NORMAL:  on = 1'b1;
					aux_reg_pkg::MODE_RESTART: on = 1'b1;
					aux_reg_pkg::MODE_STOP:    on = stop_keep;
					aux_reg_pkg::MODE_FAIL:    on = 1'b0;
					aux_reg_pkg::MODE_INIT,
					aux_reg_pkg::MODE_SLEEP:   on = 1'b0;
					default:                   on = 1'b0;
				endcase
			end
			aux_reg_pkg::CFG_NONE: on = 1'b0;
			default:               on = 1'b0;
		endcase
		return on;
	endfunction

	// register select; shared by the write strobes and the read-back mux
	// only the low address byte is decoded, so the map repeats every 256 bytes
	function automatic logic reg_hit(
		input logic [`AUX_ADDR_W-1:0] addr,
		input logic [`AUX_ADDR_W-1:0] ofs
	);
		return addr == ofs;
	endfunction

	// stage enables as {high, low}; stop runs low-power and adds high-power on demand
	function automatic logic [1:0] stage_next(
		input logic                   on,
		input aux_reg_pkg::sys_mode_t mode,
		input logic                   hp_now,
		input logic                   lp_now,
		input aux_reg_pkg::sense_t    sn
	);
		logic hp;
		logic lp;
		hp = 1'b0;
		lp = 1'b0;
		if (on && mode == aux_reg_pkg::MODE_STOP) begin
			lp = 1'b1;
			// entering stop starts from the low-power stage alone
			hp = hp_now && lp_now;
			if (sn.base_hi) begin
				hp = 1'b1;
			end else if (sn.base_lo) begin
				hp = 1'b0;
			end
		end else if (on) begin
			// outside stop the high-power stage carries the load alone
			hp = 1'b1;
		end
		return {hp, lp};
	endfunction

	// read-back images of the two registers
	// the load-share bit reads back the lock, not the last written value
	function automatic logic [`AUX_DATA_W-1:0] ctrl_word(
		input aux_reg_pkg::aux_state_t st
	);
		logic [`AUX_DATA_W-1:0] w;
		w                  = '0;
		w[`CTRL_EN_BIT]    = st.sa_on;
		w[`CTRL_LS_BIT]    = st.cfg == aux_reg_pkg::CFG_LOADSHARE;
		w[`CTRL_LVL_BIT]   = st.level_sel;
		w[`CTRL_STPK_BIT]  = st.stop_keep;
		w[`CTRL_UVOFF_BIT] = st.uv_off;
		return w;
	endfunction

	// status image; the mode field shows the mode seen in this cycle
	function automatic logic [`AUX_DATA_W-1:0] stat_word(
		input aux_reg_pkg::aux_state_t st,
		input aux_reg_pkg::sys_mode_t  mode
	);
		logic [`AUX_DATA_W-1:0] w;
		w                      = '0;
		w[`STAT_OC_BIT]        = st.oc_flag;
		w[`STAT_UV_BIT]        = st.uv_flag;
		w[`STAT_FAIL_BIT]      = st.fail_flag;
		w[`STAT_CFG_LSB +: 2]  = st.cfg;
		w[`STAT_ON_BIT]        = st.aux_on;
		w[`STAT_HP_BIT]        = st.hp_on;
		w[`STAT_LP_BIT]        = st.lp_on;
		w[`STAT_MODE_LSB +: 3] = mode;
		return w;
	endfunction

	// write strobes last exactly the one data-phase cycle
	assign wr_ctrl = wr.wr_en && reg_hit(wr.addr, `AUX_CTRL_OFS);
	assign wr_stat = wr.wr_en && reg_hit(wr.addr, `AUX_STAT_OFS);
	assign want_en = wr.wdata[`CTRL_EN_BIT];
	assign want_ls = wr.wdata[`CTRL_LS_BIT];

	always_comb begin
		s_nxt = s_r;

		// status flags clear by writing one; the sets further down win
		if (wr_stat) begin
			// overcurrent flag only yields once the condition is gone
			if (wr.wdata[`STAT_OC_BIT] && !sense.shunt_oc) begin
				s_nxt.oc_flag = 1'b0;
			end
			if (wr.wdata[`STAT_UV_BIT]) begin
				s_nxt.uv_flag = 1'b0;
			end
			if (wr.wdata[`STAT_FAIL_BIT]) begin
				s_nxt.fail_flag = 1'b0;
			end
		end

		if (wr_ctrl) begin
			s_nxt.level_sel = wr.wdata[`CTRL_LVL_BIT];
			s_nxt.stop_keep = wr.wdata[`CTRL_STPK_BIT];
			s_nxt.uv_off    = wr.wdata[`CTRL_UVOFF_BIT];
			unique case (s_r.cfg)
				aux_reg_pkg::CFG_NONE: begin
					// load-share takes priority; the enable bit then has no function
					if (want_ls) begin
						s_nxt.cfg = aux_reg_pkg::CFG_LOADSHARE;
					end else if (want_en && sys_mode == aux_reg_pkg::MODE_NORMAL) begin
						s_nxt.cfg   = aux_reg_pkg::CFG_STANDALONE;
						s_nxt.sa_on = 1'b1;
					end
				end
				aux_reg_pkg::CFG_STANDALONE: begin
					// load-share bit ignored here, no failure reported
					if (sys_mode == aux_reg_pkg::MODE_NORMAL) begin
						s_nxt.sa_on = want_en;
					end
				end
				aux_reg_pkg::CFG_LOADSHARE: begin
					if (want_en || !want_ls) begin
						s_nxt.fail_flag = 1'b1;
					end
				end
				default: s_nxt.cfg = aux_reg_pkg::CFG_NONE;
			endcase
		end

		// battery undervoltage latch; with undervoltage-off set, a control write restarts
		if (sense.battery_uv) begin
			s_nxt.uv_latch = 1'b1;
		end else if (!s_r.uv_off || wr_ctrl) begin
			s_nxt.uv_latch = 1'b0;
		end

		wanted       = mode_wants_on(s_nxt.cfg, sys_mode, s_nxt.sa_on, s_nxt.stop_keep);
		s_nxt.aux_on = wanted && !s_nxt.uv_latch;

		// level select only reaches the output in stand-alone
		s_nxt.lvl_out = s_nxt.cfg == aux_reg_pkg::CFG_STANDALONE
			&& s_nxt.level_sel;

		{s_nxt.hp_on, s_nxt.lp_on} = stage_next(s_nxt.aux_on, sys_mode, s_r.hp_on,
			s_r.lp_on, sense);

		// flags only in stand-alone; load sharing has neither current limit nor monitor
		if (s_r.cfg == aux_reg_pkg::CFG_STANDALONE && s_r.aux_on) begin
			if (sense.shunt_oc) begin
				s_nxt.oc_flag = 1'b1;
			end
			if (sense.aux_uv) begin
				s_nxt.uv_flag = 1'b1;
			end
		end

		// soft reset clears settings and flags but the lock and the stand-alone enable survive it
		if (soft_reset) begin
			s_nxt.level_sel = 1'b0;
			s_nxt.stop_keep = 1'b0;
			s_nxt.uv_off    = 1'b0;
			s_nxt.oc_flag   = 1'b0;
			s_nxt.uv_flag   = 1'b0;
			s_nxt.fail_flag = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// unmapped offsets read as zero; the slave registers this word for the data phase
	always_comb begin
		rd_data = '0;
		if (reg_hit(rd_addr, `AUX_CTRL_OFS)) begin
			rd_data = ctrl_word(s_r);
		end else if (reg_hit(rd_addr, `AUX_STAT_OFS)) begin
			rd_data = stat_word(s_r, sys_mode);
		end
	end

	// every regulator output is a field of the state register; the bus outputs come from the slave's
	assign aux_on        = s_r.aux_on;
	assign aux_level_1v8 = s_r.lvl_out;
	assign high_power_on = s_r.hp_on;
	assign low_power_on  = s_r.lp_on;
	assign serial_fail   = s_r.fail_flag;

endmodule

// [aux_reg_defs.svh]
// register map, field positions and code values of the auxiliary regulator control
`ifndef AUX_REG_DEFS_SVH
`define AUX_REG_DEFS_SVH

`define AUX_ADDR_W       8
`define AUX_DATA_W       32
`define AUX_CTRL_OFS     8'h00
`define AUX_STAT_OFS     8'h04

`define CTRL_EN_BIT      0
`define CTRL_LS_BIT      1
`define CTRL_LVL_BIT     2
`define CTRL_STPK_BIT    3
`define CTRL_UVOFF_BIT   4

`define STAT_OC_BIT      0
`define STAT_UV_BIT      1
`define STAT_FAIL_BIT    2
`define STAT_CFG_LSB     3
`define STAT_ON_BIT      5
`define STAT_HP_BIT      6
`define STAT_LP_BIT      7
`define STAT_MODE_LSB    8

`define SYS_MODE_INIT    3'h0
`define SYS_MODE_NORMAL  3'h1
`define SYS_MODE_STOP    3'h3
`define SYS_MODE_SLEEP   3'h2
`define SYS_MODE_RESTART 3'h6
`define SYS_MODE_FAIL    3'h4

`define CFG_CODE_NONE    2'h0
`define CFG_CODE_SA      2'h1
`define CFG_CODE_LS      2'h3

`define BUS_CODE_IDLE    2'h0
`define BUS_CODE_WRITE   2'h1
`define BUS_CODE_READ    2'h2

`define HTRANS_NONSEQ    2'h2
`define HSIZE_WORD       3'h2
`define SENSE_W          5

`endif

// [aux_reg_pkg.sv]
// types shared by the auxiliary regulator control modules
`include "aux_reg_defs.svh"
package aux_reg_pkg;

	typedef enum logic [2:0] {
		MODE_INIT    = `SYS_MODE_INIT,
		MODE_NORMAL  = `SYS_MODE_NORMAL,
		MODE_STOP    = `SYS_MODE_STOP,
		MODE_SLEEP   = `SYS_MODE_SLEEP,
		MODE_RESTART = `SYS_MODE_RESTART,
		MODE_FAIL    = `SYS_MODE_FAIL
	} sys_mode_t;

	typedef enum logic [1:0] {
		CFG_NONE       = `CFG_CODE_NONE,
		CFG_STANDALONE = `CFG_CODE_SA,
		CFG_LOADSHARE  = `CFG_CODE_LS
	} cfg_t;

	typedef enum logic [1:0] {
		BUS_IDLE  = `BUS_CODE_IDLE,
		BUS_WRITE = `BUS_CODE_WRITE,
		BUS_READ  = `BUS_CODE_READ
	} bus_phase_t;

	typedef struct packed {
		logic battery_uv;
		logic shunt_oc;
		logic aux_uv;
		logic base_hi;
		logic base_lo;
	} sense_t;

	typedef struct packed {
		logic                     wr_en;
		logic [`AUX_ADDR_W-1:0]   addr;
		logic [`AUX_DATA_W-1:0]   wdata;
	} reg_wr_t;

	typedef struct packed {
		bus_phase_t               phase;
		logic [`AUX_ADDR_W-1:0]   addr;
		logic [`AUX_DATA_W-1:0]   hrdata;
		logic                     hreadyout;
		logic                     hresp;
	} ahb_state_t;

	typedef struct packed {
		cfg_t cfg;
		logic sa_on;
		logic level_sel;
		logic stop_keep;
		logic uv_off;
		logic uv_latch;
		logic oc_flag;
		logic uv_flag;
		logic fail_flag;
		logic aux_on;
		logic lvl_out;
		logic hp_on;
		logic lp_on;
	} aux_state_t;

endpackage

// [pin_sync.sv]
// three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_state_t;

	sync_state_t s_r;
	sync_state_t s_nxt;

	always_comb begin
		s_nxt    = s_r;
		s_nxt.s1 = pin_in;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		for (int i = 0; i < W; i++) begin
			if (s_r.s2[i] == s_r.s3[i]) begin
				s_nxt.q[i] = s_r.s3[i];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sync_out = s_r.q;

endmodule

// [ahb_reg_slave.sv]
// ahb-lite slave front end: write strobe in the data phase, reads take one wait state
`timescale 1ns/10ps
`include "aux_reg_defs.svh"

module ahb_reg_slave (
	input  wire logic                   mclk,
	input  wire logic                   resetn,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	input  wire logic [`AUX_DATA_W-1:0] rd_data,
	output logic      [`AUX_ADDR_W-1:0] rd_addr,
	output aux_reg_pkg::reg_wr_t        wr,
	output logic      [31:0]            hrdata,
	output logic                        hreadyout,
	output logic                        hresp
);

	aux_reg_pkg::ahb_state_t s_r;
	aux_reg_pkg::ahb_state_t s_nxt;
	logic                    take;

	// only whole-word single transfers are decoded; other sizes pass as idle
	assign take = hsel && hready && htrans == `HTRANS_NONSEQ && hsize == `HSIZE_WORD;

	always_comb begin
		s_nxt           = s_r;
		s_nxt.hresp     = 1'b0;
		s_nxt.hreadyout = 1'b1;
		unique case (s_r.phase)
			aux_reg_pkg::BUS_READ: begin
				s_nxt.hrdata = rd_data;
				s_nxt.phase  = aux_reg_pkg::BUS_IDLE;
			end
			aux_reg_pkg::BUS_IDLE,
			aux_reg_pkg::BUS_WRITE: begin
				s_nxt.phase = aux_reg_pkg::BUS_IDLE;
				if (take) begin
					s_nxt.addr = haddr[`AUX_ADDR_W-1:0];
					if (hwrite) begin
						s_nxt.phase = aux_reg_pkg::BUS_WRITE;
					end else begin
						s_nxt.phase     = aux_reg_pkg::BUS_READ;
						s_nxt.hreadyout = 1'b0;
					end
				end
			end
			default: s_nxt.phase = aux_reg_pkg::BUS_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s_r           <= '0;
			s_r.hreadyout <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wr         = {s_r.phase == aux_reg_pkg::BUS_WRITE, s_r.addr, hwdata};
	assign rd_addr    = s_r.addr;
	assign hrdata     = s_r.hrdata;
	assign hreadyout  = s_r.hreadyout;
	assign hresp      = s_r.hresp;

endmodule

// [aux_ctrl_props.sv]
// assertion checker for the auxiliary regulator control ports
`timescale 1ns/10ps
module aux_ctrl_props (
	input wire logic                   mclk,
	input wire logic                   resetn,
	input wire logic                   soft_reset,
	input wire aux_reg_pkg::sys_mode_t sys_mode,
	input wire aux_reg_pkg::sense_t    sense_pins,
	input wire logic                   hsel,
	input wire logic [1:0]             htrans,
	input wire logic                   hwrite,
	input wire logic [2:0]             hsize,
	input wire logic                   hready,
	input wire logic                   hreadyout,
	input wire logic                   hresp,
	input wire logic                   aux_on,
	input wire logic                   aux_level_1v8,
	input wire logic                   high_power_on,
	input wire logic                   low_power_on,
	input wire logic                   serial_fail
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	logic take;
	logic wr_dp_r;
	assign take = hsel && hready && htrans == 2'h2 && hsize == 3'h2;
	// only a register write or a soft reset may move the sticky fail flag, so remember the write's data phase
	always_ff @(posedge mclk) begin
		wr_dp_r <= resetn && take && hwrite;
	end
	a_off_init_fail: assert property (
		(sys_mode inside {aux_reg_pkg::MODE_INIT, aux_reg_pkg::MODE_FAIL}) [*2] |-> !aux_on)
		else $error("regulator on in init or fail-safe");
	a_normal_hp_only: assert property (
		(sys_mode == aux_reg_pkg::MODE_NORMAL && aux_on) [*2] |-> high_power_on && !low_power_on)
		else $error("wrong stages in normal mode");
	a_stop_low_power: assert property (
		(sys_mode == aux_reg_pkg::MODE_STOP && aux_on) [*2] |-> low_power_on)
		else $error("low power stage off in stop mode");
	a_battery_uv_off: assert property (
		sense_pins.battery_uv [*7] |-> !aux_on)
		else $error("regulator on during battery undervoltage");
	a_fail_rise_cause: assert property (
		$rose(serial_fail) |-> $past(wr_dp_r))
		else $error("fail flag set without a write");
	a_fail_sticky: assert property (
		$fell(serial_fail) |-> $past(wr_dp_r) || $past(soft_reset))
		else $error("fail flag dropped by itself");
	a_write_no_wait: assert property (
		take && hwrite |=> hreadyout)
		else $error("write inserted a wait state");
	a_read_one_wait: assert property (
		take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state count wrong");
	a_resp_okay: assert property (
		hresp == 1'b0)
		else $error("error response seen");
	c_fail: cover property ($rose(serial_fail));
	c_both_stages: cover property (high_power_on && low_power_on);
	c_low_level: cover property (aux_level_1v8 && aux_on);
endmodule

bind aux_regulator_config_control aux_ctrl_props u_props (.mclk, .resetn, .soft_reset,
	.sys_mode, .sense_pins, .hsel, .htrans, .hwrite, .hsize, .hready, .hreadyout, .hresp,
	.aux_on, .aux_level_1v8, .high_power_on, .low_power_on, .serial_fail);

// [aux_host_model.sv]
// bus master model of the host that configures the regulator control
`timescale 1ns/10ps
module aux_host_model (
	input  wire logic   mclk,
	input  wire logic   hready,
	output logic        hsel,
	output logic [31:0] haddr,
	output logic [1:0]  htrans,
	output logic        hwrite,
	output logic [2:0]  hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// single transfer of size z; waits on hready as long as the slave wants
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] z);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= z;
		@(posedge mclk);
		while (hready !== 1'b1) @(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge mclk);
		while (hready !== 1'b1) @(posedge mclk);
		// leave no stale word on the bus once the data phase is over
		hwdata <= ~d;
	endtask
endmodule

// [aux_regulator_config_control_test.sv]
// self-checking testbench for the auxiliary regulator control
`timescale 1ns/10ps
module aux_regulator_config_control_test;
	logic                   mclk;
	logic                   resetn;
	logic                   soft_reset;
	aux_reg_pkg::sys_mode_t sys_mode;
	aux_reg_pkg::sense_t    sense_pins;
	logic                   hsel;
	logic [31:0]            haddr;
	logic [1:0]             htrans;
	logic                   hwrite;
	logic [2:0]             hsize;
	logic [31:0]            hwdata;
	logic [31:0]            hrdata;
	logic                   hreadyout;
	logic                   hresp;
	logic                   aux_on;
	logic                   aux_level_1v8;
	logic                   high_power_on;
	logic                   low_power_on;
	logic                   serial_fail;
	logic                   lo_r;
	int                     num_errors;
	int                     n_tests;
	logic [31:0]            exp_q[$];

	aux_regulator_config_control uut (.mclk, .resetn, .soft_reset, .sys_mode, .sense_pins,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .aux_on, .aux_level_1v8, .high_power_on, .low_power_on,
		.serial_fail);
	aux_host_model host (.mclk, .hready(hreadyout), .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata);

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task tk(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task rx(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		host.xfer(1'b0, a, 32'h0, 3'h2);
	endtask
	// status word: mode, {low, high, on}, config, {fail, uv, oc}
	task st(input logic [2:0] f, input logic [1:0] c, input logic [2:0] p);
		rx(8'h04, {21'h0, sys_mode, p, c, f});
	endtask
	task cw(input logic [4:0] b);
		host.xfer(1'b1, 8'h00, {27'($urandom()), b}, 3'h2);
	endtask
	task clr(input logic [2:0] f);
		host.xfer(1'b1, 8'h04, {29'h0, f}, 3'h2);
	endtask
	task md(input aux_reg_pkg::sys_mode_t m);
		sys_mode <= m;
		tk(3);
	endtask
	// synchroniser plus control register need several edges
	task sn(input logic [4:0] v);
		sense_pins <= v;
		tk(8);
	endtask
	task rst;
		resetn <= 1'b0;
		sys_mode <= aux_reg_pkg::MODE_INIT;
		tk(8);
		resetn <= 1'b1;
		tk(1);
	endtask
	task complete_run;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge mclk) begin
		if (hreadyout === 1'b1 && lo_r)
			chk(hrdata, exp_q.pop_front(), "hrdata");
		lo_r <= (hreadyout === 1'b0);
	end

	// whole sequence takes a few hundred cycles; this bound is far beyond it
	initial begin
		#100000;
		num_errors++;
		complete_run();
	end

	initial begin
		soft_reset = 1'b0;
		sense_pins = '0;
		num_errors = 0;
		n_tests = 0;
		void'($urandom(65957));
		rst();
		cw(5'h01);
		st(3'h0, 2'h0, 3'h0);
		md(aux_reg_pkg::MODE_NORMAL);
		cw(5'h05);
		st(3'h0, 2'h1, 3'h3);
		rx(8'h00, 32'h5);
		chk(32'(aux_level_1v8), 32'h1, "level");
		cw(5'h07);
		st(3'h0, 2'h1, 3'h3);
		cw(5'h04);
		st(3'h0, 2'h1, 3'h0);
		cw(5'h05);
		md(aux_reg_pkg::MODE_STOP);
		st(3'h0, 2'h1, 3'h5);
		sn(5'h02);
		st(3'h0, 2'h1, 3'h7);
		sn(5'h01);
		st(3'h0, 2'h1, 3'h5);
		sn(5'h00);
		cw(5'h04);
		st(3'h0, 2'h1, 3'h5);
		md(aux_reg_pkg::MODE_INIT);
		st(3'h0, 2'h1, 3'h0);
		md(aux_reg_pkg::MODE_SLEEP);
		st(3'h0, 2'h1, 3'h3);
		md(aux_reg_pkg::MODE_NORMAL);
		sn(5'h08);
		st(3'h1, 2'h1, 3'h3);
		clr(3'h1);
		st(3'h1, 2'h1, 3'h3);
		sn(5'h00);
		clr(3'h1);
		st(3'h0, 2'h1, 3'h3);
		sn(5'h04);
		st(3'h2, 2'h1, 3'h3);
		sn(5'h00);
		clr(3'h2);
		sn(5'h10);
		st(3'h0, 2'h1, 3'h0);
		sn(5'h00);
		st(3'h0, 2'h1, 3'h3);
		cw(5'h15);
		sn(5'h10);
		sn(5'h00);
		st(3'h0, 2'h1, 3'h0);
		cw(5'h05);
		st(3'h0, 2'h1, 3'h3);
		// a byte-sized write must be ignored, else it would switch the regulator off
		host.xfer(1'b1, 8'h00, 32'h0, 3'h0);
		st(3'h0, 2'h1, 3'h3);
		soft_reset <= 1'b1;
		tk(1);
		soft_reset <= 1'b0;
		tk(2);
		st(3'h0, 2'h1, 3'h3);
		chk(32'(aux_level_1v8), 32'h0, "level");
		rx(8'h10, 32'h0);
		rst();
		cw(5'h06);
		st(3'h0, 2'h3, 3'h0);
		rx(8'h00, 32'h6);
		md(aux_reg_pkg::MODE_NORMAL);
		st(3'h0, 2'h3, 3'h3);
		chk(32'(aux_level_1v8), 32'h0, "level");
		md(aux_reg_pkg::MODE_RESTART);
		st(3'h0, 2'h3, 3'h3);
		cw(5'h07);
		st(3'h4, 2'h3, 3'h3);
		chk(32'(serial_fail), 32'h1, "fail");
		clr(3'h4);
		cw(5'h06);
		st(3'h0, 2'h3, 3'h3);
		md(aux_reg_pkg::MODE_STOP);
		st(3'h0, 2'h3, 3'h0);
		md(aux_reg_pkg::MODE_NORMAL);
		st(3'h0, 2'h3, 3'h3);
		cw(5'h0a);
		md(aux_reg_pkg::MODE_STOP);
		st(3'h0, 2'h3, 3'h5);
		md(aux_reg_pkg::MODE_NORMAL);
		sn(5'h0c);
		st(3'h0, 2'h3, 3'h3);
		sn(5'h00);
		md(aux_reg_pkg::MODE_FAIL);
		st(3'h0, 2'h3, 3'h0);
		tk(4);
		chk(32'(exp_q.size()), 32'h0, "pending");
		complete_run();
	end
endmodule
